/* File: bench/core_mem_model.sv */
// Behavioural core memory and private index registers
`timescale 1ns/1ns
module core_mem_model
  import decode_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic slow_in,
  input wire logic mem_req_in,
  input wire logic [ADDR_W-1:0] mem_addr_in,
  output logic mem_ack_out,
  output logic [WORD_W-1:0] mem_data_out,
  input wire logic [XSEL_W-1:0] index_select_in,
  output logic [WORD_W-1:0] index_data_out
);
  logic [WORD_W-1:0] xr [8];
  logic [WORD_W-1:0] word;
  logic [2:0] wait_cnt, next_wait_cnt;
  logic next_ack;
  // Upper 15 bits are junk so only the low 17 bits may form the pointer
  assign word = {mem_addr_in[14:0], ~mem_addr_in};
  // Off the ack cycle the bus shows the inverse, never a stale match
  assign mem_data_out = mem_ack_out ? word : ~word;
  assign index_data_out = xr[index_select_in];
  always_comb begin
    next_ack = 1'b0;
    next_wait_cnt = 3'h0;
    if (mem_req_in && !mem_ack_out) begin
      next_ack = (wait_cnt == (slow_in ? 3'h3 : 3'h0));
      next_wait_cnt = next_ack ? 3'h0 : wait_cnt + 3'h1;
    end
  end
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mem_ack_out <= 1'b0;
      wait_cnt <= 3'h0;
    end else begin
      mem_ack_out <= next_ack;
      wait_cnt <= next_wait_cnt;
    end
  end
endmodule

/* File: bench/instr_decode_assertions.sv */
// Concurrent checks on the decoder's instruction and memory ports
`timescale 1ns/1ns
module instr_decode_checker
  import decode_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic [WORD_W-1:0] instr_in,
  input wire logic instr_valid_in,
  input wire logic immediate_in,
  input wire logic no_memory_in,
  input wire logic doubleword_in,
  input wire logic instr_ready_out,
  input wire logic mem_req_out,
  input wire logic [ADDR_W-1:0] mem_addr_out,
  input wire logic mem_ack_in,
  input wire logic [XSEL_W-1:0] index_select_out,
  input wire logic [OPCODE_W-1:0] opcode_out,
  input wire logic [RSEL_W-1:0] reg_select_out,
  input wire logic [WORD_W-1:0] operand_out,
  input wire logic [ADDR_W-1:0] ea_out,
  input wire logic mem_access_out,
  input wire logic trap_out,
  input wire logic result_valid_out,
  input wire logic result_ready_in
);
  logic take;
  logic [34:0] held, next_held;
  assign take = instr_valid_in && instr_ready_out;
  // Class bits ride with the word: 34 dword, 33 no memory, 32 immediate
  always_comb begin
    next_held = held;
    if (take) begin
      next_held = {doubleword_in, no_memory_in, immediate_in, instr_in};
    end
  end
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      held <= 35'h0;
    end else begin
      held <= next_held;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_field_split: assert property (result_valid_out |->
    opcode_out == held[30:24] && reg_select_out == held[23:20])
    else $error("opcode or register field wrong");
  a_index_field: assert property (result_valid_out |->
    index_select_out == held[19:17]) else $error("index field wrong");
  a_direct_ea: assert property (result_valid_out && held[34:31] == 4'h0 &&
    held[19:17] == 3'h0 |-> mem_access_out && ea_out == held[16:0])
    else $error("plain address altered");
  a_trap_vector: assert property (result_valid_out && held[32] && held[31] |->
    trap_out && ea_out == TRAP_ADDR) else $error("trap missing");
  a_imm_sext: assert property (result_valid_out && held[32] |->
    operand_out == {{12{held[19]}}, held[19:0]}) else $error("bad operand");
  a_imm_quick: assert property (take && immediate_in |=>
    result_valid_out && !mem_access_out) else $error("immediate slow");
  a_no_fetch: assert property (take &&
    (!instr_in[31] || immediate_in || no_memory_in) |=> (!mem_req_out)[*2])
    else $error("unwanted fetch");
  a_ind_fetch: assert property (take && instr_in[31] &&
    !immediate_in && !no_memory_in |=> mem_req_out ##0
    mem_addr_out == held[16:0]) else $error("pointer fetch wrong");
  a_one_level: assert property (mem_req_out && mem_ack_in |=>
    (!mem_req_out)[*2]) else $error("second indirection");
  a_result_hold: assert property (result_valid_out && !result_ready_in |=>
    result_valid_out && $stable(ea_out)) else $error("result dropped");
  c_fetch: cover property (mem_req_out && mem_ack_in);
  c_trap: cover property (result_valid_out && trap_out);
  c_post_index: cover property (result_valid_out && held[31] &&
    held[19:17] != 3'h0 && mem_access_out);
endmodule
bind instr_decode_ea instr_decode_checker u_chk (.*);

/* File: bench/tb_top.sv */
// Self-checking bench for the instruction decoder
`timescale 1ns/1ns
module tb_top import decode_pkg::*; ;
  logic ref_clk_in, reset_n_in, instr_valid_in, immediate_in, no_memory_in;
  logic doubleword_in, instr_ready_out, mem_req_out, mem_ack_in, mem_slow;
  logic mem_access_out, trap_out, result_valid_out, result_ready_in, irq_out;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb;
  logic [REG_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [WORD_W-1:0] instr_in, mem_data_in, index_data_in, operand_out;
  logic [WORD_W-1:0] s_axi_wdata, s_axi_rdata, w, rd;
  logic [ADDR_W-1:0] mem_addr_out, ea_out;
  logic [XSEL_W-1:0] index_select_out;
  logic [OPCODE_W-1:0] opcode_out;
  logic [RSEL_W-1:0] reg_select_out;
  int n_fail = 0;
  int checks = 0;
  int i, seed;
  instr_decode_ea dut (.*);
  core_mem_model u_mem (.ref_clk_in, .reset_n_in, .slow_in(mem_slow),
    .mem_req_in(mem_req_out), .mem_addr_in(mem_addr_out),
    .mem_ack_out(mem_ack_in), .mem_data_out(mem_data_in),
    .index_select_in(index_select_out), .index_data_out(index_data_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Handshakes are judged at the falling edge, acted on at the next rise
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] resp);
    logic ta, tw, got;
    logic [1:0] rs;
    @(posedge ref_clk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge ref_clk_in);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      got = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge ref_clk_in);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (got) break;
    end
    s_axi_bready <= 1'b0;
    // A response that never came must not pass on a stale code
    chk(got, 1'b1);
    chk(rs, resp);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     input logic [1:0] resp);
    logic ta, got;
    logic [1:0] rs;
    @(posedge ref_clk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge ref_clk_in);
      ta = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid;
      d = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge ref_clk_in);
      if (ta) s_axi_arvalid <= 1'b0;
      if (got) break;
    end
    s_axi_rready <= 1'b0;
    chk(got, 1'b1);
    chk(rs, resp);
  endtask
  task automatic run(input logic [31:0] wd, input logic imm, nm, dw);
    logic [16:0] ea;
    logic ma, tr;
    ma = !imm && !nm;
    tr = imm && wd[31];
    ea = imm ? 17'h0 : wd[16:0];
    // Model memory holds the inverted address in its low 17 bits
    if (ma && wd[31]) ea = ~ea;
    if (ma && wd[19:17] != 3'h0) ea = ea + u_mem.xr[wd[19:17]][16:0];
    if (ma && dw) ea[0] = 1'b0;
    if (tr) ea = TRAP_ADDR;
    @(posedge ref_clk_in);
    instr_in <= wd;
    immediate_in <= imm;
    no_memory_in <= nm;
    doubleword_in <= dw;
    instr_valid_in <= 1'b1;
    mem_slow <= 1'($urandom_range(1));
    // Word stays offered until the decoder is seen ready
    for (int n = 0; n < 50; n++) begin
      @(negedge ref_clk_in);
      if (instr_ready_out === 1'b1) break;
    end
    @(posedge ref_clk_in);
    instr_valid_in <= 1'b0;
    for (int n = 0; n < 50; n++) begin
      @(negedge ref_clk_in);
      if (result_valid_out === 1'b1) break;
    end
    chk(result_valid_out, 1'b1);
    chk(ea_out, ea);
    chk(mem_access_out, ma);
    chk(trap_out, tr);
    chk(opcode_out, wd[30:24]);
    chk(reg_select_out, wd[23:20]);
    if (imm) chk(operand_out, {{12{wd[19]}}, wd[19:0]});
    repeat ($urandom_range(2)) @(posedge ref_clk_in);
    @(posedge ref_clk_in);
    result_ready_in <= 1'b1;
    @(posedge ref_clk_in);
    result_ready_in <= 1'b0;
  endtask
  initial begin
    {reset_n_in, instr_valid_in, immediate_in, no_memory_in} = 4'h0;
    {doubleword_in, result_ready_in, mem_slow, s_axi_awvalid} = 4'h0;
    {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 4'h0;
    {instr_in, s_axi_wdata, s_axi_awaddr, s_axi_araddr} = 80'h0;
    s_axi_wstrb = 4'hf;
    seed = $urandom(37250);
    for (i = 0; i < 8; i++) u_mem.xr[i] = $urandom;
    repeat (20) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    axr(CTRL_OFS, rd, RESP_OKAY);
    chk(rd, 32'(CTRL_RESET));
    axr(STATUS_OFS, rd, RESP_OKAY);
    chk(rd, 32'(STATUS_RESET));
    axr(MASK_OFS, rd, RESP_OKAY);
    chk(rd, 32'(MASK_RESET));
    axw(8'h14, 32'h7, RESP_SLVERR);
    axr(8'h14, rd, RESP_SLVERR);
    chk(rd, 32'h0);
    $display("test registers done");
    for (i = 0; i < 60; i++) begin
      w = $urandom;
      rd[1:0] = 2'($urandom_range(3));
      run(w, rd[1:0] == 2'h0, rd[1:0] == 2'h1, 1'($urandom_range(1)));
    end
    $display("test random decode done");
    u_mem.xr[5] = 32'h000044ec;
    run(32'h38ca0407, 1'b0, 1'b0, 1'b0);
    axr(LAST_EA_OFS, rd, RESP_OKAY);
    chk(rd, 32'h48f3);
    u_mem.xr[1] = 32'h2;
    run(32'h3213ffff, 1'b0, 1'b0, 1'b1);
    axr(LAST_INSTR_OFS, rd, RESP_OKAY);
    chk(rd, 32'h3213ffff);
    $display("test address boundary done");
    axr(STATUS_OFS, rd, RESP_OKAY);
    axw(MASK_OFS, 32'h7, RESP_OKAY);
    run(32'h80000123, 1'b0, 1'b0, 1'b0);
    @(negedge ref_clk_in);
    chk(irq_out, 1'b1);
    axr(STATUS_OFS, rd, RESP_OKAY);
    chk(rd, 32'h5);
    chk(irq_out, 1'b0);
    run(32'h80000000, 1'b1, 1'b0, 1'b0);
    axw(MASK_OFS, 32'h0, RESP_OKAY);
    chk(irq_out, 1'b0);
    axr(STATUS_OFS, rd, RESP_OKAY);
    chk(rd, 32'h2);
    $display("test interrupt done");
    axw(CTRL_OFS, 32'h0, RESP_OKAY);
    @(negedge ref_clk_in);
    chk(instr_ready_out, 1'b0);
    axw(CTRL_OFS, 32'h1, RESP_OKAY);
    @(negedge ref_clk_in);
    chk(instr_ready_out, 1'b1);
    // Without the low byte lane the write must leave enable alone
    s_axi_wstrb <= 4'he;
    axw(CTRL_OFS, 32'h0, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    @(negedge ref_clk_in);
    chk(instr_ready_out, 1'b1);
    $display("test enable done");
    summarize();
  end
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_fail++;
    summarize();
  end
endmodule

/* File: core/decode_pkg.sv */
// Constants shared by the instruction decoder and its helpers
package decode_pkg;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 17;
  // Bit 0 of the word (most significant) is index 31 here
  localparam int IND_BIT = 31;
  localparam int OPCODE_MSB = 30;
  localparam int OPCODE_LSB = 24;
  localparam int RSEL_MSB = 23;
  localparam int RSEL_LSB = 20;
  localparam int XSEL_MSB = 19;
  localparam int XSEL_LSB = 17;
  localparam int REF_MSB = 16;
  localparam int REF_LSB = 0;
  localparam int IMM_SIGN = 19;
  localparam int IMM_LSB = 0;
  localparam int OPCODE_W = 7;
  localparam int RSEL_W = 4;
  localparam int XSEL_W = 3;
  localparam logic [ADDR_W-1:0] TRAP_ADDR = 17'h00040;
  // Register map, byte addresses
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [REG_AW-1:0] STATUS_OFS = 8'h04;
  localparam logic [REG_AW-1:0] MASK_OFS = 8'h08;
  localparam logic [REG_AW-1:0] LAST_EA_OFS = 8'h0c;
  localparam logic [REG_AW-1:0] LAST_INSTR_OFS = 8'h10;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [0:0] CTRL_RESET = 1'h1;
  localparam int EVENT_W = 3;
  localparam int EV_DONE_BIT = 0;
  localparam int EV_TRAP_BIT = 1;
  localparam int EV_IND_BIT = 2;
  localparam logic [EVENT_W-1:0] STATUS_RESET = 3'h0;
  localparam logic [EVENT_W-1:0] MASK_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_INDEX = 4'b0100,
    ST_DONE = 4'b1000
  } dec_state_t;
endpackage

/* File: core/ea_adder.sv */
// Forms the effective address from a base and an index value
`timescale 1ns/1ns
module ea_adder
  import decode_pkg::*;
(
  input wire logic [ADDR_W-1:0] base_in,
  input wire logic [WORD_W-1:0] index_in,
  input wire logic index_en_in,
  input wire logic dword_in,
  output logic [ADDR_W-1:0] ea_out
);
  logic [ADDR_W-1:0] addend;
  logic [ADDR_W-1:0] sum;

  // Zero select means no indexing at all
  assign addend = index_en_in ? index_in[ADDR_W-1:0] : '0; // (RULE5)
  // Carry out of the top address bit is dropped on purpose
  assign sum = base_in + addend; // (RULE17)
  assign ea_out = dword_in ? {sum[ADDR_W-1:1], 1'b0} : sum; // (RULE15)
endmodule

/* File: core/instr_decode_ea.sv */
// Instruction decoder with effective address formation and register slave
// Contract
// (RULE1) Opcode is taken from instruction bits 1 to 7, bit 0 most significant.
// (RULE2) Bits 8 to 11 select one of sixteen general registers.
// (RULE3) Bits 15 to 31 are the reference address for memory operands.
// (RULE4) Bits 12 to 14 select index register 1 to 7.
// (RULE5) Nonzero index select adds that register; zero means no indexing.
// (RULE6) Bit 0 is the indirect flag; exactly one indirect level is done.
// (RULE7) Indirect: read word at reference address, use it as address.
// (RULE8) Indirect and indexed: index is added after the pointer fetch.
// (RULE9) Final address goes out as effective address; unmodified equals ref.
// (RULE10) Shift, I/O, read and write direct never use the field for memory.
// (RULE11) Immediate instructions use the word's own operand, no memory, no index.
// (RULE12) Immediate with bit 0 set aborts and traps to location 40 hex.
// (RULE13) Immediate operand bits 12 to 31 are sign extended to 32 bits.
// (RULE14) Immediate instructions still pass on the register select field.
// (RULE15) Doubleword references force the address least significant bit to zero.
// (RULE16) Indirect pointer is the low 17 bits of the fetched word.
// (RULE17) Effective address sum is cut to 17 bits, carry discarded.
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
module instr_decode_ea
  import decode_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic [WORD_W-1:0] instr_in,
  input wire logic instr_valid_in,
  input wire logic immediate_in,
  input wire logic no_memory_in,
  input wire logic doubleword_in,
  output logic instr_ready_out,
  output logic mem_req_out,
  output logic [ADDR_W-1:0] mem_addr_out,
  input wire logic mem_ack_in,
  input wire logic [WORD_W-1:0] mem_data_in,
  output logic [XSEL_W-1:0] index_select_out,
  input wire logic [WORD_W-1:0] index_data_in,
  output logic [OPCODE_W-1:0] opcode_out,
  output logic [RSEL_W-1:0] reg_select_out,
  output logic [WORD_W-1:0] operand_out,
  output logic [ADDR_W-1:0] ea_out,
  output logic mem_access_out,
  output logic trap_out,
  output logic result_valid_out,
  input wire logic result_ready_in,
  input wire logic [REG_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [WORD_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [REG_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [WORD_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq_out
);
  dec_state_t state;
  dec_state_t next_state;
  logic [WORD_W-1:0] instr;
  logic [WORD_W-1:0] next_instr;
  logic imm;
  logic next_imm;
  logic nomem;
  logic next_nomem;
  logic dword;
  logic next_dword;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] next_base;
  logic [ADDR_W-1:0] ea;
  logic [ADDR_W-1:0] next_ea;
  logic mem_acc;
  logic next_mem_acc;
  logic trap;
  logic next_trap;
  logic [EVENT_W-1:0] events;

  logic ind_flag;
  logic [XSEL_W-1:0] xsel;
  logic [ADDR_W-1:0] ref_addr;
  logic [WORD_W-1:0] imm_val;
  logic [ADDR_W-1:0] indexed_ea;

  logic enable;
  logic next_enable;
  logic [EVENT_W-1:0] status;
  logic [EVENT_W-1:0] next_status;
  logic [EVENT_W-1:0] mask;
  logic [EVENT_W-1:0] next_mask;
  logic aw_held;
  logic next_aw_held;
  logic [REG_AW-1:0] aw_addr;
  logic [REG_AW-1:0] next_aw_addr;
  logic w_held;
  logic next_w_held;
  logic [WORD_W-1:0] w_data;
  logic [WORD_W-1:0] next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;
  logic bvalid;
  logic next_bvalid;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic rvalid;
  logic next_rvalid;
  logic [WORD_W-1:0] rdata;
  logic [WORD_W-1:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;
  logic do_write;
  logic do_read;
  logic status_read;

  // Decoding shared by the read and the write path
  function automatic logic mapped(input logic [REG_AW-1:0] a);
    mapped = (a == CTRL_OFS) || (a == STATUS_OFS) || (a == MASK_OFS) ||
             (a == LAST_EA_OFS) || (a == LAST_INSTR_OFS);
  endfunction

  instr_fields fields (
    .instr_in(instr),
    .indirect_flag_out(ind_flag),
    .opcode_out(opcode_out),
    .reg_select_out(reg_select_out), // (RULE14)
    .index_select_out(xsel),
    .ref_addr_out(ref_addr),
    .imm_operand_out(imm_val)
  );

  ea_adder adder (
    .base_in(base),
    .index_in(index_data_in),
    .index_en_in(xsel != '0), // (RULE5)
    .dword_in(dword),
    .ea_out(indexed_ea)
  );

  assign instr_ready_out = state == ST_IDLE && enable;
  assign mem_req_out = state == ST_FETCH;
  assign mem_addr_out = ref_addr; // (RULE7)
  assign index_select_out = xsel;
  assign operand_out = imm_val; // (RULE11)
  assign ea_out = ea;
  assign mem_access_out = mem_acc;
  assign trap_out = trap;
  assign result_valid_out = state == ST_DONE;

  always_comb begin
    next_state = state;
    next_instr = instr;
    next_imm = imm;
    next_nomem = nomem;
    next_dword = dword;
    next_base = base;
    next_ea = ea;
    next_mem_acc = mem_acc;
    next_trap = trap;
    events = '0;
    unique case (state)
      ST_IDLE: begin
        if (instr_valid_in && enable) begin
          next_instr = instr_in;
          next_imm = immediate_in;
          next_nomem = no_memory_in;
          next_dword = doubleword_in && !immediate_in && !no_memory_in;
          next_base = instr_in[REF_MSB:REF_LSB];
          next_trap = 1'b0;
          next_mem_acc = 1'b0;
          if (immediate_in) begin
            // No fetch and no index; indirect flag aborts it
            if (instr_in[IND_BIT]) begin
              next_trap = 1'b1; // (RULE12)
              next_ea = TRAP_ADDR; // (RULE12)
            end else begin
              next_ea = '0; // (RULE11)
            end
            next_state = ST_DONE;
          end else if (no_memory_in) begin
            // Field is control data, passed on but not a memory address
            next_ea = instr_in[REF_MSB:REF_LSB]; // (RULE10)
            next_state = ST_DONE;
          end else if (instr_in[IND_BIT]) begin
            next_state = ST_FETCH; // (RULE6)
          end else begin
            next_state = ST_INDEX;
          end
        end
      end
      ST_FETCH: begin
        if (mem_ack_in) begin
          // Pointer word is never itself treated as indirect
          next_base = mem_data_in[ADDR_W-1:0]; // (RULE16)
          events[EV_IND_BIT] = 1'b1;
          next_state = ST_INDEX; // (RULE6)
        end
      end
      ST_INDEX: begin
        // Index applied to the fetched pointer if indirect, else to the field
        next_ea = indexed_ea; // (RULE8)
        next_mem_acc = 1'b1; // (RULE9)
        next_state = ST_DONE;
      end
      ST_DONE: begin
        if (result_ready_in) begin
          events[EV_DONE_BIT] = !trap;
          events[EV_TRAP_BIT] = trap;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= ST_IDLE;
      instr <= '0;
      imm <= 1'b0;
      nomem <= 1'b0;
      dword <= 1'b0;
      base <= '0;
      ea <= '0;
      mem_acc <= 1'b0;
      trap <= 1'b0;
    end else begin
      state <= next_state;
      instr <= next_instr;
      imm <= next_imm;
      nomem <= next_nomem;
      dword <= next_dword;
      base <= next_base;
      ea <= next_ea;
      mem_acc <= next_mem_acc;
      trap <= next_trap;
    end
  end

  // Register slave; one write and one read in flight at most
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign irq_out = |(status & mask);

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_enable = enable;
    next_mask = mask;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    do_write = aw_held && w_held && !bvalid;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      // Only the low byte lane carries writable bits
      if (w_strb[0]) begin
        if (aw_addr == CTRL_OFS) begin
          next_enable = w_data[CTRL_EN_BIT];
        end
        if (aw_addr == MASK_OFS) begin
          next_mask = w_data[EVENT_W-1:0];
        end
      end
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    do_read = s_axi_arvalid && s_axi_arready;
    status_read = do_read && s_axi_araddr == STATUS_OFS;
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        CTRL_OFS: next_rdata = {{(WORD_W-1){1'b0}}, enable};
        STATUS_OFS: next_rdata = {{(WORD_W-EVENT_W){1'b0}}, status};
        MASK_OFS: next_rdata = {{(WORD_W-EVENT_W){1'b0}}, mask};
        LAST_EA_OFS: next_rdata = {{(WORD_W-ADDR_W){1'b0}}, ea};
        LAST_INSTR_OFS: next_rdata = instr;
        default: next_rdata = '0;
      endcase
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    // Read clears, but an event in the same cycle survives
    next_status = (status_read ? '0 : status) | events;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
      enable <= CTRL_RESET[0];
      status <= STATUS_RESET;
      mask <= MASK_RESET;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      enable <= next_enable;
      status <= next_status;
      mask <= next_mask;
    end
  end
endmodule

/* File: core/instr_fields.sv */
// Splits an instruction word into its fields
`timescale 1ns/1ns
module instr_fields
  import decode_pkg::*;
(
  input wire logic [WORD_W-1:0] instr_in,
  output logic indirect_flag_out,
  output logic [OPCODE_W-1:0] opcode_out,
  output logic [RSEL_W-1:0] reg_select_out,
  output logic [XSEL_W-1:0] index_select_out,
  output logic [ADDR_W-1:0] ref_addr_out,
  output logic [WORD_W-1:0] imm_operand_out
);
  localparam int IMM_W = IMM_SIGN - IMM_LSB + 1;

  assign indirect_flag_out = instr_in[IND_BIT]; // (RULE6)
  assign opcode_out = instr_in[OPCODE_MSB:OPCODE_LSB]; // (RULE1)
  assign reg_select_out = instr_in[RSEL_MSB:RSEL_LSB]; // (RULE2)
  assign index_select_out = instr_in[XSEL_MSB:XSEL_LSB]; // (RULE4)
  assign ref_addr_out = instr_in[REF_MSB:REF_LSB]; // (RULE3)
  // Sign bit copied into all upper bits
  assign imm_operand_out = {{(WORD_W-IMM_W){instr_in[IMM_SIGN]}},
                            instr_in[IMM_SIGN:IMM_LSB]}; // (RULE13)
endmodule
